// ### src/uim_irq.sv
// Purpose: interrupt enable, disable, mask and pending status for a usb device port
// Assumes: apb slave, one clock, endpoint flags kept outside in each endpoint register
// Notes:   endpoint pending bits are live ORs of outside flags, bus bits are sticky here
// How it works
// - enable register ones set endpoint mask bits 0..7; zeros change nothing
// - disable register ones clear endpoint mask bits 0..7; zeros change nothing
// - mask register reads one for each enabled endpoint interrupt
// - suspend source sits at bit 8; one enables or disables it
// - host resume source sits at bit 9 of all four registers
// - external resume source sits at bit 10 of all four registers
// - start-of-frame source sits at bit 11 of all four registers
// - bus wakeup source sits at bit 13 of all four registers
// - mask register shows enabled state of every bus-level source
// - host resume mask bit comes out of reset enabled
// - status bits 0..7 read one while that endpoint has an interrupt pending
// - endpoint status raised when any of its five flags is set
// - endpoint status stays until software clears the flag; status writes ignored
// - ones written to clear register clear bus-level pending bits
// - suspend status raised after three milliseconds of bus idle
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module uim_irq #(
    parameter int unsigned IDLE_CYCLES = uim_pkg::IDLE_SUSPEND_CYC
) (
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire uim_pkg::uim_ep_flags_s    ep_flags [uim_pkg::NUM_EP],
    input  wire uim_pkg::uim_bus_events_s  bus_events,
    input  wire logic                      bus_activity,
    output logic                           suspended,
    output logic                           irq
);
    logic [13:0] mask;
    logic [13:0] bus_pending;
    logic [7:0]  ep_pending;
    logic [13:0] pending;
    logic [31:0] idle_count;
    logic        idle_reached;
    logic        wr_en;
    logic        rd_en;
    logic        set_suspend_chk;
    logic [13:0] set_v;
    logic [13:0] clr_v;

    // address decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == uim_pkg::OFS_ENABLE_SET) || (a == uim_pkg::OFS_ENABLE_CLEAR) ||
               (a == uim_pkg::OFS_ENABLE_VIEW) || (a == uim_pkg::OFS_PENDING_VIEW) ||
               (a == uim_pkg::OFS_PENDING_CLR);
    endfunction : is_mapped

    // zero-wait slave; unmapped addresses answer with pslverr
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !is_mapped(paddr);

    // mask: set wins over clear when both hit the same bit in one cycle is impossible (separate addresses)
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask <= uim_pkg::MASK_RESET;
        end else if (wr_en && paddr == uim_pkg::OFS_ENABLE_SET) begin
            mask <= mask | (pwdata[13:0] & uim_pkg::MASK_WRITABLE);
        end else if (wr_en && paddr == uim_pkg::OFS_ENABLE_CLEAR) begin
            mask <= mask & ~(pwdata[13:0] & uim_pkg::MASK_WRITABLE);
        end
    end

    // endpoint pending is the live OR of its flags, so it clears only with them
    generate
        for (genvar i = 0; i < uim_pkg::NUM_EP; i++) begin : g_ep
            assign ep_pending[i] = |ep_flags[i];
        end
    endgenerate

    // idle timer; saturates so suspend fires once per idle period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idle_count <= 32'h0000_0000;
        end else if (bus_activity) begin
            idle_count <= 32'h0000_0000;
        end else if (!idle_reached) begin
            idle_count <= idle_count + 32'h0000_0001;
        end
    end
    assign idle_reached = (idle_count >= IDLE_CYCLES - 1);

    // suspended state follows the idle detector
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspended <= 1'b0;
        end else begin
            suspended <= idle_reached && !bus_activity;
        end
    end

    // suspend fires only on the cycle the idle count is reached, not on every cycle of suspend
    assign set_suspend_chk = idle_reached && !bus_activity && !suspended;

    // set and clear vectors for the sticky bus-level bits
    always_comb begin
        set_v = 14'h0000;
        clr_v = 14'h0000;
        set_v[uim_pkg::BIT_SUSPEND]      = set_suspend_chk;
        set_v[uim_pkg::BIT_HOST_RESUME]  = bus_events.host_resume;
        set_v[uim_pkg::BIT_EXT_RESUME]   = bus_events.external_resume;
        set_v[uim_pkg::BIT_FRAME_START]  = bus_events.frame_start;
        set_v[uim_pkg::BIT_BUS_RST_DONE] = bus_events.bus_reset_done;
        set_v[uim_pkg::BIT_WAKEUP]       = bus_events.wakeup;
        if (wr_en && paddr == uim_pkg::OFS_PENDING_CLR) begin
            clr_v = pwdata[13:0] & uim_pkg::BUS_EVENT_BITS;
        end
    end

    // sticky bus-level pending bits; a new event wins over a clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus_pending <= 14'h0000;
        end else begin
            bus_pending <= (bus_pending & ~clr_v) | set_v;
        end
    end

    assign pending = {bus_pending[13:8], ep_pending};

    // read data registered in setup phase, valid during access
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                uim_pkg::OFS_ENABLE_VIEW:  prdata <= {18'h00000, mask};
                uim_pkg::OFS_PENDING_VIEW: prdata <= {18'h00000, pending};
                default:                   prdata <= 32'h0000_0000;
            endcase
        end
    end

    // level interrupt output
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending & mask);
        end
    end

    a_mask_set: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == uim_pkg::OFS_ENABLE_SET |=> ((mask & $past(pwdata[13:0]) & uim_pkg::MASK_WRITABLE)
            == ($past(pwdata[13:0]) & uim_pkg::MASK_WRITABLE)))
        else $error("enable write did not set mask");
    a_mask_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == uim_pkg::OFS_ENABLE_CLEAR |=> ((mask & $past(pwdata[13:0]) & uim_pkg::MASK_WRITABLE)
            == 14'h0000))
        else $error("disable write did not clear mask");
    a_mask_readback: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_en && paddr == uim_pkg::OFS_ENABLE_VIEW |=> prdata[13:0] == $past(mask))
        else $error("mask read mismatch");
    a_bit12_unused: assert property (@(posedge mclk) disable iff (!reset_n)
        mask[uim_pkg::BIT_BUS_RST_DONE] == uim_pkg::MASK_RESET[uim_pkg::BIT_BUS_RST_DONE])
        else $error("mask bit 12 changed");
    a_ep_status: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_en && paddr == uim_pkg::OFS_PENDING_VIEW |=> prdata[7:0] == $past(ep_pending))
        else $error("endpoint status read mismatch");
    a_ep_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(ep_pending[0]) |-> ep_flags[0] == 5'h00)
        else $error("endpoint pending lost");
    a_bus_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && paddr == uim_pkg::OFS_PENDING_CLR && pwdata[uim_pkg::BIT_FRAME_START] && !bus_events.frame_start
        |=> !bus_pending[uim_pkg::BIT_FRAME_START])
        else $error("clear did not clear frame start");
    a_event_wins: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_events.wakeup |=> bus_pending[uim_pkg::BIT_WAKEUP])
        else $error("wakeup event lost");
    a_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
        |(pending & mask) |=> irq)
        else $error("irq not raised");
    a_suspend_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        set_suspend_chk |=> bus_pending[uim_pkg::BIT_SUSPEND])
        else $error("suspend status not raised");

    c_ep_irq:   cover property (@(posedge mclk) disable iff (!reset_n) ep_pending[0] && mask[0] ##1 irq);
    c_suspend:  cover property (@(posedge mclk) disable iff (!reset_n) $rose(suspended));
    c_clr_sof:  cover property (@(posedge mclk) disable iff (!reset_n) $fell(bus_pending[uim_pkg::BIT_FRAME_START]));
endmodule : uim_irq

// ### src/uim_pkg.sv
// Purpose: constants and types for the usb device interrupt mask/status block
// Assumes: 32-bit apb, 100 MHz mclk
// Notes:   register offsets are byte addresses
package uim_pkg;
    localparam logic [7:0]  OFS_ENABLE_SET   = 8'h10;
    localparam logic [7:0]  OFS_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0]  OFS_ENABLE_VIEW  = 8'h18;
    localparam logic [7:0]  OFS_PENDING_VIEW = 8'h1C;
    localparam logic [7:0]  OFS_PENDING_CLR  = 8'h20;
    localparam int          NUM_EP           = 8;
    localparam int          BIT_SUSPEND      = 8;
    localparam int          BIT_HOST_RESUME  = 9;
    localparam int          BIT_EXT_RESUME   = 10;
    localparam int          BIT_FRAME_START  = 11;
    localparam int          BIT_BUS_RST_DONE = 12;
    localparam int          BIT_WAKEUP       = 13;
    // bits that the enable/disable registers can change; mask bit 12 stays at its reset value
    localparam logic [13:0] MASK_WRITABLE    = 14'h2FFF;
    // bits that the clear register acts on
    localparam logic [13:0] BUS_EVENT_BITS   = 14'h3F00;
    localparam logic [13:0] MASK_RESET       = 14'h1200;
    localparam int          CLK_MHZ          = 100;
    localparam int          IDLE_SUSPEND_MS  = 3;
    localparam int          IDLE_SUSPEND_CYC = IDLE_SUSPEND_MS * 1000 * 1000 * CLK_MHZ / 1000;

    // per-endpoint flags from each endpoint control/status register
    typedef struct packed {
        logic setup_received_flag;
        logic bank_zero_received_flag;
        logic bank_one_received_flag;
        logic transmit_done_flag;
        logic stall_sent_flag;
    } uim_ep_flags_s;

    // bus-level event pulses from the protocol engine
    typedef struct packed {
        logic host_resume;
        logic external_resume;
        logic frame_start;
        logic bus_reset_done;
        logic wakeup;
    } uim_bus_events_s;
endpackage : uim_pkg

// ### verification/tb_top.sv
// Purpose: self-checking bench for the usb device interrupt mask/status block
// Assumes: bench is the apb master; idle count shortened to IDLE cycles
// Notes:   expectations come from the bit map, never from design outputs
`timescale 1ns/100ps
module tb_top;
    localparam int         IDLE = 20;
    localparam logic [7:0] SET  = uim_pkg::OFS_ENABLE_SET;
    localparam logic [7:0] DIS  = uim_pkg::OFS_ENABLE_CLEAR;
    localparam logic [7:0] VIEW = uim_pkg::OFS_ENABLE_VIEW;
    localparam logic [7:0] PEND = uim_pkg::OFS_PENDING_VIEW;
    localparam logic [7:0] CLR  = uim_pkg::OFS_PENDING_CLR;
    logic                     mclk         = 1'b0;
    logic                     reset_n      = 1'b0;
    logic                     psel         = 1'b0;
    logic                     penable      = 1'b0;
    logic                     pwrite       = 1'b0;
    logic [7:0]               paddr        = 8'h00;
    logic [31:0]              pwdata       = 32'h0;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    uim_pkg::uim_ep_flags_s   ep_flags [uim_pkg::NUM_EP] = '{default: '0};
    uim_pkg::uim_bus_events_s bus_events   = '0;
    logic                     bus_activity = 1'b1;
    logic                     suspended;
    logic                     irq;
    logic [31:0]              rd;
    logic                     err_seen;
    int                       num_errors   = 0;
    int                       checks_done  = 0;
    int                       cycles       = 0;
    int                       bb [5]       = '{8, 9, 10, 11, 13};

    uim_irq #(.IDLE_CYCLES(IDLE)) dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ep_flags(ep_flags), .bus_events(bus_events), .bus_activity(bus_activity), .suspended(suspended),
        .irq(irq));

    always #5 mclk = ~mclk;

    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; an idle edge after it so no signal is driven twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdchk(VIEW, 32'h0000_1200);
        rdchk(PEND, 32'h0000_0000);
        rdchk(8'h24, 32'h0000_0000);
        chk({31'h0, err_seen}, 32'h1);
        $display("test reset done");
        // all on, then a pattern off; mask bit 12 stays set throughout
        apb(1'b1, SET, 32'hFFFF_FFFF);
        rdchk(VIEW, 32'h0000_3FFF);
        apb(1'b1, DIS, 32'h0000_10A5);
        rdchk(VIEW, 32'h0000_3F5A);
        apb(1'b1, SET, 32'h0000_0000);
        rdchk(VIEW, 32'h0000_3F5A);
        apb(1'b1, DIS, 32'hFFFF_FFFF);
        rdchk(VIEW, 32'h0000_1000);
        foreach (bb[i]) begin
            apb(1'b1, SET, 32'h1 << bb[i]);
            rdchk(VIEW, (32'h1 << bb[i]) | 32'h0000_1000);
            apb(1'b1, DIS, 32'h1 << bb[i]);
            rdchk(VIEW, 32'h0000_1000);
        end
        $display("test mask done");
        // every endpoint, the five flag kinds in turn; status writes must not clear
        for (int e = 0; e < 8; e++) begin
            ep_flags[e] <= 5'h01 << (e % 5);
            @(posedge mclk);
            rdchk(PEND, 32'h1 << e);
            apb(1'b1, PEND, 32'hFFFF_FFFF);
            rdchk(PEND, 32'h1 << e);
            ep_flags[e] <= '0;
            @(posedge mclk);
            rdchk(PEND, 32'h0000_0000);
        end
        apb(1'b1, SET, 32'h0000_0008);
        ep_flags[3] <= 5'h01;
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, DIS, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        ep_flags[3] <= '0;
        $display("test endpoint done");
        // struct bit i of the events lands on status bit 13 - i
        for (int i = 0; i < 5; i++) begin
            bus_events <= 5'h01 << i;
            @(posedge mclk);
            bus_events <= '0;
            @(posedge mclk);
            rdchk(PEND, 32'h1 << (13 - i));
            apb(1'b1, CLR, 32'h0000_0000);
            rdchk(PEND, 32'h1 << (13 - i));
            apb(1'b1, CLR, 32'h1 << (13 - i));
            rdchk(PEND, 32'h0000_0000);
        end
        $display("test bus events done");
        bus_activity <= 1'b0;
        repeat (IDLE / 2) @(posedge mclk);
        chk({31'h0, suspended}, 32'h0);
        repeat (IDLE) @(posedge mclk);
        chk({31'h0, suspended}, 32'h1);
        rdchk(PEND, 32'h0000_0100);
        apb(1'b1, CLR, 32'h0000_0100);
        bus_activity <= 1'b1;
        rdchk(PEND, 32'h0000_0000);
        $display("test suspend done");
        report_and_stop();
    end
endmodule : tb_top
